// >>> clk_low_timer.sv
/*
 Measures continuous clock-low time in core clock cycles and pulses once
 when it reaches the limit. Assumes the clock level is already synchronised.
*/
`timescale 1ns/1ps
module clk_low_timer
#(
    parameter int unsigned CNT_W = 23
)
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_scl_low,
    input  wire logic [CNT_W-1:0] i_limit,
    output logic                  o_expired
);

    logic [CNT_W-1:0] cnt_r;
    logic             fired_r;

    // Saturating so a stuck line fires exactly once
    always_ff @(posedge i_clk)
    begin
        if (i_rst || !i_scl_low)
        begin
            cnt_r   <= '0;
            fired_r <= 1'b0;
        end
        else if (!fired_r)
        begin
            if (cnt_r == i_limit)
            begin
                fired_r <= 1'b1;
            end
            else
            begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign o_expired = i_scl_low && !fired_r && (cnt_r == i_limit);

endmodule : clk_low_timer

// >>> smbus_bus_master.sv
/*
 Behavioural two-wire bus master facing the slave.
 Assumes the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
module smbus_bus_master
(
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_low,
    output logic      o_sda_low
);
    localparam realtime Q = 31.25;

    initial
    begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end

    // Released clock waits for the slave, so stretching is honoured
    task automatic bit_io(input logic b, output logic s);
        #(Q) o_sda_low = !b;
        #(Q) o_scl_low = 1'b0;
        wait (i_scl === 1'b1);
        #(2 * Q) s = i_sda;
        o_scl_low = 1'b1;
    endtask : bit_io

    task automatic start();
        #(Q) o_sda_low = 1'b1;
        #(2 * Q) o_scl_low = 1'b1;
    endtask : start

    task automatic rstart();
        #(Q) o_sda_low = 1'b0;
        #(Q) o_scl_low = 1'b0;
        #(Q) o_sda_low = 1'b1;
        #(Q) o_scl_low = 1'b1;
    endtask : rstart

    task automatic stop();
        #(Q) o_sda_low = 1'b1;
        #(Q) o_scl_low = 1'b0;
        #(Q) o_sda_low = 1'b0;
    endtask : stop

    task automatic wr(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : wr

    task automatic rd(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(!ack, s);
    endtask : rd
endmodule : smbus_bus_master

// >>> smbus_slave_match.sv
/*
 Two-wire bus slave: 7-bit and 10-bit address recognition, general call,
 alert response, second address and range matching, received bytes queued
 in a FIFO, and clock-low timeout handling. Assumes open-drain pads outside
 driven low while an enable is high, and a 125 MHz core clock.
*/
`timescale 1ns/1ps
module smbus_slave_match
    import smbus_slave_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = CLK_LOW_TIMEOUT_CYCLES,
    parameter int unsigned FIFO_DEPTH  = RX_FIFO_DEPTH
)
(
    input  wire logic                I_CORE_CLK,
    input  wire logic                I_RST,
    input  wire logic                I_SCL_IN,
    input  wire logic                I_SDA_IN,
    output logic                     O_SCL_OUT,
    output logic                     O_SCL_OE,
    output logic                     O_SDA_OUT,
    output logic                     O_SDA_OE,
    input  wire match_cfg_t          I_MATCH_CFG,
    input  wire logic [TO_CNT_W-1:0] I_TIMEOUT_LIMIT,
    input  wire logic                I_MASTER_ACTIVE,
    input  wire logic                I_TIMEOUT_FLAG_CLEAR,
    input  wire logic                I_INT_ENABLE,
    input  wire logic [7:0]          I_TX_DATA,
    output logic                     O_TX_TAKEN,
    output logic                     O_RX_VALID,
    input  wire logic                I_RX_READY,
    output rx_word_t                 O_RX_WORD,
    output logic                     O_ADDRESSED_AS_SLAVE_FLAG,
    output logic                     O_SLAVE_TRANSMIT,
    output logic                     O_CLOCK_LOW_TIMEOUT_FLAG,
    output logic                     O_MASTER_STOP_REQ,
    output logic                     O_BYTE_EVENT,
    output logic                     O_IRQ
);

    function automatic logic ten_prefix_hit(input logic [6:0] a, input match_cfg_t c);
        ten_prefix_hit = c.ext_en && (a[6:2] == TEN_BIT_PREFIX)
                         && (a[1:0] == c.high[2:1]);
    endfunction : ten_prefix_hit

    function automatic logic seven_hit(input logic [6:0] a, input match_cfg_t c);
        logic in_range;
        in_range  = c.range_en && (c.range != '0) && (a > c.primary) && (a <= c.range);
        seven_hit = (a == c.primary)
                    || (c.gc_en && (a == GENERAL_CALL_ADDR))
                    || (c.alert_en && (a == ALERT_RESPONSE_ADDR))
                    || (c.second_en && (a == c.second))
                    || in_range;
    endfunction : seven_hit

    logic [1:0]  scl_sync_r;
    logic [1:0]  sda_sync_r;
    logic        scl_q_r;
    logic        sda_q_r;
    logic        scl;
    logic        sda;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;

    slv_state_t  state_r;
    byte_kind_t  kind_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  tx_shift_r;
    logic        sda_low_r;
    logic        master_ack_r;
    logic        addressed_r;
    logic        ten_selected_r;
    logic        slave_tx_r;
    logic        timeout_flag_r;
    logic        stop_req_r;
    logic        event_r;

    logic        ack_c;
    logic        ten_write_c;
    byte_kind_t  next_kind_c;
    logic        byte_done;
    logic        decide_go;
    logic        stall;
    logic        load_tx;
    logic        fifo_in_ready;
    logic        timeout_hit;
    logic [TO_CNT_W-1:0] limit_eff;
    rx_word_t    rx_word;

    // Only the second stage of each synchroniser feeds logic
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            scl_sync_r <= SYNC_RESET;
            sda_sync_r <= SYNC_RESET;
            scl_q_r    <= 1'b1;
            sda_q_r    <= 1'b1;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], I_SCL_IN};
            sda_sync_r <= {sda_sync_r[0], I_SDA_IN};
            scl_q_r    <= scl_sync_r[1];
            sda_q_r    <= sda_sync_r[1];
        end
    end

    assign scl       = scl_sync_r[1];
    assign sda       = sda_sync_r[1];
    assign scl_rise  = scl && !scl_q_r;
    assign scl_fall  = !scl && scl_q_r;
    assign start_det = scl && scl_q_r && !sda && sda_q_r;
    assign stop_det  = scl && scl_q_r && sda && !sda_q_r;

    always_comb
    begin
        ack_c       = 1'b0;
        ten_write_c = 1'b0;
        next_kind_c = KIND_DATA;
        case (kind_r)
            KIND_ADDR1:
            begin
                if (ten_prefix_hit(shift_r[7:1], I_MATCH_CFG))
                begin
                    if (!shift_r[0])
                    begin
                        ack_c       = 1'b1;
                        ten_write_c = 1'b1;
                        next_kind_c = KIND_ADDR2;
                    end
                    else
                    begin
                        ack_c       = ten_selected_r;
                        next_kind_c = KIND_TX;
                    end
                end
                else if (seven_hit(shift_r[7:1], I_MATCH_CFG))
                begin
                    ack_c       = 1'b1;
                    next_kind_c = shift_r[0] ? KIND_TX : KIND_DATA;
                end
            end
            KIND_ADDR2:
            begin
                ack_c = (shift_r == {I_MATCH_CFG.high[0], I_MATCH_CFG.primary});
            end
            KIND_DATA:
            begin
                ack_c = 1'b1;
            end
            default:
            begin
                ack_c = 1'b0;
            end
        endcase
    end

    // Every accepted byte is queued; a full FIFO stretches SCL instead of dropping
    assign byte_done = (state_r == ST_RECV) && scl_fall && (bit_cnt_r == BYTE_BITS);
    assign stall     = byte_done && ack_c && !fifo_in_ready;
    assign decide_go = (byte_done && !(ack_c && !fifo_in_ready))
                       || ((state_r == ST_STRETCH) && fifo_in_ready);
    assign load_tx   = scl_fall && (((state_r == ST_ACK) && (kind_r == KIND_TX))
                       || ((state_r == ST_TX_ACK) && master_ack_r));

    // Address bytes are tagged so software can tell them from data
    assign rx_word.is_addr = (kind_r != KIND_DATA);
    assign rx_word.data    = shift_r;

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST || timeout_hit)
        begin
            state_r   <= ST_IDLE;
            kind_r    <= KIND_ADDR1;
            bit_cnt_r <= '0;
            sda_low_r <= 1'b0;
        end
        else if (stop_det)
        begin
            state_r   <= ST_IDLE;
            sda_low_r <= 1'b0;
        end
        else if (start_det)
        begin
            state_r   <= ST_RECV;
            kind_r    <= KIND_ADDR1;
            bit_cnt_r <= '0;
            sda_low_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_RECV:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                    end
                    if (stall)
                    begin
                        state_r <= ST_STRETCH;
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_low_r <= 1'b0;
                        bit_cnt_r <= '0;
                        state_r   <= ST_RECV;
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == LAST_TX_BIT)
                        begin
                            sda_low_r <= 1'b0;
                            state_r   <= ST_TX_ACK;
                        end
                        else
                        begin
                            sda_low_r <= !tx_shift_r[6];
                            bit_cnt_r <= bit_cnt_r + 1'b1;
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_fall && !master_ack_r)
                    begin
                        state_r <= ST_IGNORE;
                    end
                end
                default:
                begin
                    state_r <= state_r;
                end
            endcase
            if (decide_go)
            begin
                kind_r    <= next_kind_c;
                sda_low_r <= ack_c;
                state_r   <= ack_c ? ST_ACK : ST_IGNORE;
            end
            if (load_tx)
            begin
                sda_low_r <= !I_TX_DATA[7];
                bit_cnt_r <= '0;
                state_r   <= ST_TX;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            shift_r      <= '0;
            tx_shift_r   <= '0;
            master_ack_r <= 1'b0;
        end
        else
        begin
            if ((state_r == ST_RECV) && scl_rise)
            begin
                shift_r <= {shift_r[6:0], sda};
            end
            if ((state_r == ST_TX_ACK) && scl_rise)
            begin
                master_ack_r <= !sda;
            end
            if (load_tx)
            begin
                tx_shift_r <= I_TX_DATA;
            end
            else if ((state_r == ST_TX) && scl_fall)
            begin
                tx_shift_r <= {tx_shift_r[6:0], 1'b0};
            end
        end
    end

    // Selection memory survives a repeated START so a 10-bit read can follow
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST || timeout_hit || stop_det)
        begin
            addressed_r    <= 1'b0;
            ten_selected_r <= 1'b0;
            slave_tx_r     <= 1'b0;
        end
        else if (decide_go && (kind_r == KIND_ADDR1))
        begin
            addressed_r    <= ack_c && !ten_write_c;
            ten_selected_r <= ack_c && ten_selected_r && shift_r[0];
            slave_tx_r     <= ack_c && shift_r[0];
        end
        else if (decide_go && (kind_r == KIND_ADDR2))
        begin
            addressed_r    <= ack_c;
            ten_selected_r <= ack_c;
            slave_tx_r     <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
        begin
            timeout_flag_r <= 1'b0;
            stop_req_r     <= 1'b0;
            event_r        <= 1'b0;
        end
        else
        begin
            // A new timeout beats a clear in the same cycle
            if (timeout_hit)
            begin
                timeout_flag_r <= 1'b1;
            end
            else if (I_TIMEOUT_FLAG_CLEAR)
            begin
                timeout_flag_r <= 1'b0;
            end
            stop_req_r <= timeout_hit && I_MASTER_ACTIVE;
            event_r    <= decide_go && ack_c;
        end
    end

    assign limit_eff = (I_TIMEOUT_LIMIT == '0) ? TIMEOUT_CYC[TO_CNT_W-1:0]
                                               : I_TIMEOUT_LIMIT;

    clk_low_timer #(
        .CNT_W     (TO_CNT_W)
    ) u_timer (
        .i_clk     (I_CORE_CLK),
        .i_rst     (I_RST),
        .i_scl_low (!scl),
        .i_limit   (limit_eff),
        .o_expired (timeout_hit)
    );

    sync_fifo #(
        .WIDTH       ($bits(rx_word_t)),
        .DEPTH       (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk       (I_CORE_CLK),
        .i_rst       (I_RST),
        .i_in_valid  (decide_go && ack_c),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (rx_word),
        .o_out_valid (O_RX_VALID),
        .i_out_ready (I_RX_READY),
        .o_out_data  (O_RX_WORD)
    );

    assign O_SCL_OUT                 = 1'b0;
    assign O_SDA_OUT                 = 1'b0;
    assign O_SCL_OE                  = (state_r == ST_STRETCH);
    assign O_SDA_OE                  = sda_low_r;
    assign O_TX_TAKEN                = load_tx;
    assign O_ADDRESSED_AS_SLAVE_FLAG = addressed_r;
    assign O_SLAVE_TRANSMIT          = slave_tx_r;
    assign O_CLOCK_LOW_TIMEOUT_FLAG  = timeout_flag_r;
    assign O_MASTER_STOP_REQ         = stop_req_r;
    assign O_BYTE_EVENT              = event_r;
    // Interrupt is a combination of the sticky flag and the byte pulse
    assign O_IRQ                     = I_INT_ENABLE && (timeout_flag_r || event_r);

endmodule : smbus_slave_match

// >>> smbus_slave_match_chk.sv
/*
 Port checker for smbus_slave_match, bound to every instance.
 Assumes the top module's port names and parameters.
*/
`timescale 1ns/1ps
module smbus_slave_match_chk
    import smbus_slave_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = CLK_LOW_TIMEOUT_CYCLES,
    parameter int unsigned FIFO_DEPTH  = RX_FIFO_DEPTH
)
(
    input wire logic                I_CORE_CLK,
    input wire logic                I_RST,
    input wire logic                I_SCL_IN,
    input wire logic [TO_CNT_W-1:0] I_TIMEOUT_LIMIT,
    input wire logic                I_MASTER_ACTIVE,
    input wire logic                I_TIMEOUT_FLAG_CLEAR,
    input wire logic                I_INT_ENABLE,
    input wire logic                O_SCL_OUT,
    input wire logic                O_SCL_OE,
    input wire logic                O_SDA_OUT,
    input wire logic                O_SDA_OE,
    input wire logic                O_TX_TAKEN,
    input wire logic                O_ADDRESSED_AS_SLAVE_FLAG,
    input wire logic                O_SLAVE_TRANSMIT,
    input wire logic                O_CLOCK_LOW_TIMEOUT_FLAG,
    input wire logic                O_MASTER_STOP_REQ,
    input wire logic                O_BYTE_EVENT,
    input wire logic                O_IRQ
);
    logic [31:0] low_cnt_r;
    logic [31:0] lim;

    assign lim = (I_TIMEOUT_LIMIT != '0) ? 32'(I_TIMEOUT_LIMIT) : 32'(TIMEOUT_CYC);

    // Raw pin time; the synchroniser delay is allowed for in the bounds
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST || I_SCL_IN)
            low_cnt_r <= '0;
        else
            low_cnt_r <= low_cnt_r + 32'h1;
    end

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    sequence drive_off;
        !O_SDA_OE && !O_SCL_OE;
    endsequence
    sequence flag_set;
        $rose(O_CLOCK_LOW_TIMEOUT_FLAG);
    endsequence

    open_drain_a: assert property (!O_SCL_OUT && !O_SDA_OUT)
        else $error("line driven high");
    irq_mask_a: assert property (O_IRQ == (I_INT_ENABLE && (O_CLOCK_LOW_TIMEOUT_FLAG || O_BYTE_EVENT)))
        else $error("irq mismatch");
    early_timeout_a: assert property (flag_set |-> low_cnt_r > lim)
        else $error("timeout too early");
    late_timeout_a: assert property (low_cnt_r == lim + 32'hC |-> O_CLOCK_LOW_TIMEOUT_FLAG)
        else $error("timeout missing");
    bus_release_a: assert property (
        flag_set |-> drive_off ##1 (drive_off and !O_ADDRESSED_AS_SLAVE_FLAG))
        else $error("bus not released");
    stop_pulse_a: assert property (O_MASTER_STOP_REQ |-> (O_CLOCK_LOW_TIMEOUT_FLAG && $past(I_MASTER_ACTIVE)) ##1 !O_MASTER_STOP_REQ)
        else $error("bad stop request");
    stop_seen_a: assert property ($rose(O_CLOCK_LOW_TIMEOUT_FLAG) && $past(I_MASTER_ACTIVE) |-> O_MASTER_STOP_REQ)
        else $error("stop request missing");
    flag_clear_a: assert property ($fell(O_CLOCK_LOW_TIMEOUT_FLAG) |-> $past(I_TIMEOUT_FLAG_CLEAR) || $past(I_RST))
        else $error("flag fell alone");
    addr_ack_a: assert property ($rose(O_ADDRESSED_AS_SLAVE_FLAG) |-> ##[0:2] O_SDA_OE)
        else $error("address not acked");
    tx_select_a: assert property (O_TX_TAKEN || $rose(O_SLAVE_TRANSMIT) |-> O_ADDRESSED_AS_SLAVE_FLAG)
        else $error("transmit unselected");
endmodule : smbus_slave_match_chk

bind smbus_slave_match smbus_slave_match_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

// >>> smbus_slave_pkg.sv
/*
 Shared constants and types for the two-wire slave address matcher with
 clock-low timeout. Assumes a 125 MHz core clock.
*/
package smbus_slave_pkg;

    localparam logic [4:0] TEN_BIT_PREFIX      = 5'h1E;
    localparam logic [6:0] GENERAL_CALL_ADDR   = 7'h00;
    localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;
    localparam logic [3:0] BYTE_BITS           = 4'h8;
    localparam logic [3:0] LAST_TX_BIT         = 4'h7;

    localparam int unsigned CORE_CLK_KHZ           = 125000;
    localparam int unsigned CLK_LOW_TIMEOUT_MS     = 35;
    localparam int unsigned CLK_LOW_TIMEOUT_CYCLES = CLK_LOW_TIMEOUT_MS * CORE_CLK_KHZ;
    localparam int unsigned TO_CNT_W               = 23;
    localparam int unsigned RX_FIFO_DEPTH          = 32;

    localparam logic [1:0] SYNC_RESET = 2'h3;

    typedef struct packed {
        logic [6:0] primary;
        logic [2:0] high;
        logic       ext_en;
        logic       gc_en;
        logic       alert_en;
        logic       second_en;
        logic [6:0] second;
        logic       range_en;
        logic [6:0] range;
    } match_cfg_t;

    typedef struct packed {
        logic       is_addr;
        logic [7:0] data;
    } rx_word_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_STRETCH,
        ST_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } slv_state_t;

    typedef enum logic [1:0] {
        KIND_ADDR1,
        KIND_ADDR2,
        KIND_DATA,
        KIND_TX
    } byte_kind_t;

endpackage : smbus_slave_pkg

// >>> sync_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides. Assumes one clock and a
 synchronous active-high reset.
*/
`timescale 1ns/1ps
module sync_fifo
#(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 32
)
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);

    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_r;
    logic [PW-1:0]    rd_r;
    logic [PW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_r != DEPTH[PW:0]);
    assign o_out_valid = (cnt_r != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_r];

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop)
            begin
                rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule : sync_fifo

// >>> tb_smbus_slave_match.sv
/*
 Self-checking bench for the two-wire slave matcher.
 Assumes the master model and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_smbus_slave_match;
    import smbus_slave_pkg::*;
    localparam logic [TO_CNT_W-1:0] LIMIT = 23'h0000C8;
    localparam logic [11:0] TAB [10] = '{12'h801, 12'h000, 12'h419, 12'h018, 12'h267,
                                         12'h066, 12'h157, 12'h161, 12'h162, 12'h056};
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       mact, fclr, ien, rdy, ack, m_scl, m_sda, scl_oe, sda_oe;
    logic       tx_taken, rx_valid, aas, stx, tflag, sreq, bev, irq;
    logic [7:0] txd, d;
    match_cfg_t cfg;
    rx_word_t   word;
    rx_word_t   q [$];
    int         nev, nsreq, fail_count, checks, cyc;
    wire        scl = !(m_scl || scl_oe === 1'b1);
    wire        sda = !(m_sda || sda_oe === 1'b1);

    always #4 clk = ~clk;

    smbus_bus_master u_smbus_bus_master (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl),
                                         .o_sda_low(m_sda));

    smbus_slave_match #(.TIMEOUT_CYC(300)) u_smbus_slave_match (
        .I_CORE_CLK(clk), .I_RST(rst), .I_SCL_IN(scl), .I_SDA_IN(sda), .O_SCL_OUT(),
        .O_SCL_OE(scl_oe), .O_SDA_OUT(), .O_SDA_OE(sda_oe), .I_MATCH_CFG(cfg),
        .I_TIMEOUT_LIMIT(LIMIT), .I_MASTER_ACTIVE(mact), .I_TIMEOUT_FLAG_CLEAR(fclr),
        .I_INT_ENABLE(ien), .I_TX_DATA(txd), .O_TX_TAKEN(tx_taken), .O_RX_VALID(rx_valid),
        .I_RX_READY(rdy), .O_RX_WORD(word), .O_ADDRESSED_AS_SLAVE_FLAG(aas),
        .O_SLAVE_TRANSMIT(stx), .O_CLOCK_LOW_TIMEOUT_FLAG(tflag),
        .O_MASTER_STOP_REQ(sreq), .O_BYTE_EVENT(bev), .O_IRQ(irq));

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic wr1(input logic [7:0] b, input logic e);
        u_smbus_bus_master.wr(b, ack);
        tick(2);
        chk(9'(ack), 9'(e), "ack");
    endtask : wr1

    // Sampled just after the falling edge, once the bench's own drives have landed
    always @(negedge clk)
    begin
        #1;
        cyc++;
        if (rx_valid === 1'b1 && rdy)
            q.push_back(word);
        if (bev === 1'b1)
            nev++;
        if (sreq === 1'b1)
            nsreq++;
        if (cyc == 20000)
        begin
            fail_count++;
            $display("Error at %0t: run hung", $time);
            end_of_test();
        end
    end

    initial
    begin
        cfg = '0;
        cfg.primary = 7'h2A;
        cfg.high = 3'h5;
        cfg.second = 7'h33;
        cfg.range = 7'h30;
        {mact, fclr, ien, rdy, txd} = 12'h330;
        tick(2);
        rst = 1'b0;
        tick(3);
        u_smbus_bus_master.start();
        wr1(8'h54, 1'b1);
        chk(9'(aas), 9'h001, "addressed");
        wr1(8'hA5, 1'b1);
        u_smbus_bus_master.stop();
        tick(4);
        chk(9'(aas), 9'h000, "stop deselects");
        chk(q[0], 9'h154, "address word");
        chk(q[1], 9'h0A5, "data word");
        chk(9'(nev), 9'h002, "byte events");
        $display("Test write7 done");
        foreach (TAB[i])
        begin
            tick(1);
            {cfg.gc_en, cfg.alert_en, cfg.second_en, cfg.range_en} = TAB[i][11:8];
            u_smbus_bus_master.start();
            wr1({TAB[i][7:1], 1'b0}, TAB[i][0]);
            chk(9'(aas), 9'(TAB[i][0]), "match flag");
            u_smbus_bus_master.stop();
        end
        tick(1);
        {cfg.gc_en, cfg.alert_en, cfg.second_en, cfg.range_en, cfg.ext_en} = 5'h01;
        $display("Test match table done");
        nev = 0;
        q.delete();
        u_smbus_bus_master.start();
        wr1(8'hF4, 1'b1);
        chk(9'(nev), 9'h001, "first byte event");
        chk(9'(aas), 9'h000, "half selected");
        wr1(8'hAA, 1'b1);
        chk(9'(aas), 9'h001, "selected");
        chk(q[0], 9'h1F4, "first byte marked");
        txd = 8'h96;
        u_smbus_bus_master.rstart();
        wr1(8'hF5, 1'b1);
        chk(9'(stx), 9'h001, "transmitter");
        u_smbus_bus_master.rd(1'b0, d);
        tick(1);
        chk(9'(d), 9'h096, "read byte");
        u_smbus_bus_master.rstart();
        wr1(8'hF6, 1'b0);
        u_smbus_bus_master.rstart();
        wr1(8'hF4, 1'b1);
        wr1(8'hAB, 1'b0);
        u_smbus_bus_master.rstart();
        wr1(8'hF5, 1'b0);
        u_smbus_bus_master.rstart();
        wr1(8'hF4, 1'b1);
        wr1(8'hAA, 1'b1);
        u_smbus_bus_master.rstart();
        wr1(8'h40, 1'b0);
        chk(9'({aas, stx}), 9'h000, "foreign deselects");
        u_smbus_bus_master.stop();
        $display("Test ten-bit done");
        tick(1);
        {cfg.ext_en, mact} = 2'h1;
        u_smbus_bus_master.start();
        wr1(8'h54, 1'b1);
        tick(240);
        chk(9'(tflag), 9'h001, "timeout flag");
        chk(9'(nsreq), 9'h001, "stop request");
        chk(9'({scl_oe, sda_oe, aas}), 9'h000, "released");
        chk(9'(irq), 9'h001, "irq");
        ien = 1'b0;
        tick(1);
        chk(9'(irq), 9'h000, "irq masked");
        {ien, fclr} = 2'h3;
        tick(1);
        fclr = 1'b0;
        tick(1);
        chk(9'(tflag), 9'h000, "flag cleared");
        u_smbus_bus_master.stop();
        u_smbus_bus_master.start();
        wr1(8'h54, 1'b1);
        u_smbus_bus_master.stop();
        $display("Test timeout done");
        tick(1);
        {mact, rdy} = 2'h0;
        q.delete();
        u_smbus_bus_master.start();
        wr1(8'h54, 1'b1);
        for (int i = 0; i < 31; i++)
            wr1(8'(i), 1'b1);
        fork
            wr1(8'hEE, 1'b1);
            begin
                for (int n = 0; n < 300 && scl_oe !== 1'b1; n++)
                    tick(1);
                chk(9'(scl_oe), 9'h001, "stretch when full");
                chk(9'(q.size()), 9'h000, "nothing popped");
                tick(20);
                rdy = 1'b1;
            end
        join
        u_smbus_bus_master.stop();
        tick(40);
        chk(9'(q.size()), 9'h021, "drained");
        for (int i = 0; i < 31; i++)
            chk(q[i + 1], {1'b0, 8'(i)}, "fifo order");
        chk(q[32], 9'h0EE, "last word");
        chk(9'(rx_valid), 9'h000, "empty");
        $display("Test fifo done");
        end_of_test();
    end
endmodule : tb_smbus_slave_match
